// ===== hw/flash_status_host.sv
// host controller: polls flash status, reads status register, clears errors
`timescale 1ns/10ps
module flash_status_host (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flash pins
  output logic [flash_status_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [flash_status_pkg::DATA_W-1:0] flash_dq_in,
  output logic [flash_status_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic ready_busy_n
);
  typedef enum {st_idle, st_rd, st_rd_gap, st_wr, st_eval} state_t;
  state_t state_reg, state_next;

  logic [flash_status_pkg::DATA_W-1:0] dq_meta_reg, dq_sync_reg;
  logic rb_meta_reg, rb_sync_reg;
  logic [flash_status_pkg::ADDR_W-1:0] addr_reg;
  logic [flash_status_pkg::DATA_W-1:0] first_reg, data_reg;
  logic [7:0] sr_reg;
  logic [2:0] op_reg, result_reg;
  logic [1:0] reads_reg;
  logic [flash_status_pkg::CNT_W-1:0] cnt_reg;
  logic busy_reg, err_pending_reg, sec_tog_reg;
  logic [flash_status_pkg::DATA_W-1:0] cmd_reg;

  // masked polling view: reserved bits four and zero ignored
  function automatic logic [7:0] poll_mask(input logic [15:0] d);
    poll_mask = {d[7:5], 1'b0, d[3:1], 1'b0};
  endfunction : poll_mask

  wire start = reg_wr && (reg_addr == flash_status_pkg::REG_CTRL) && !busy_reg;
  wire [2:0] new_op = reg_wdata[2:0];
  wire is_write_op = (new_op == flash_status_pkg::OP_CLEAR) || (new_op == flash_status_pkg::OP_ABORT_RESET)
    || (new_op == flash_status_pkg::OP_SR_READ);
  // while error pending only array read is refused; poll, status read, reset, clear go out
  wire op_allowed = !err_pending_reg || (new_op != flash_status_pkg::OP_ARRAY_READ);
  wire cnt_done = (cnt_reg == '0);
  wire [7:0] p_first = poll_mask(first_reg);
  wire [7:0] p_now = poll_mask(dq_sync_reg);
  wire toggling = p_first[flash_status_pkg::TOGGLE_ONE_BIT] != p_now[flash_status_pkg::TOGGLE_ONE_BIT];
  wire sec_toggling = p_first[flash_status_pkg::SECTOR_TOGGLE_BIT] != p_now[flash_status_pkg::SECTOR_TOGGLE_BIT];
  wire timed_out = p_now[flash_status_pkg::TIMEOUT_BIT];
  wire aborted = p_now[flash_status_pkg::ABORT_BIT];
  wire [2:0] poll_result = !toggling ? flash_status_pkg::RES_DONE :
    aborted ? flash_status_pkg::RES_ABORT :
    timed_out ? flash_status_pkg::RES_TIMEOUT : flash_status_pkg::RES_BUSY;
  wire [15:0] cmd_word = (new_op == flash_status_pkg::OP_CLEAR) ? flash_status_pkg::CMD_SR_CLEAR :
    (new_op == flash_status_pkg::OP_ABORT_RESET) ? flash_status_pkg::CMD_ABORT_RESET :
    flash_status_pkg::CMD_SR_READ;

  // state sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        if (start && op_allowed) begin
          state_next = is_write_op ? st_wr : st_rd;
        end
      end
      st_wr: begin
        if (cnt_done) begin
          state_next = (op_reg == flash_status_pkg::OP_SR_READ) ? st_rd : st_idle;
        end
      end
      st_rd: begin
        if (cnt_done) begin
          state_next = (op_reg == flash_status_pkg::OP_POLL && reads_reg == 2'd0) ? st_rd_gap : st_eval;
        end
      end
      st_rd_gap: state_next = st_rd;
      st_eval: state_next = st_idle;
      default: state_next = st_idle;
    endcase
  end

  // synchronisers for pin inputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
      rb_meta_reg <= 1'b1;
      rb_sync_reg <= 1'b1;
    end else if (clk_en) begin
      dq_meta_reg <= flash_dq_in;
      dq_sync_reg <= dq_meta_reg;
      rb_meta_reg <= ready_busy_n;
      rb_sync_reg <= rb_meta_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= st_idle;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // operation bookkeeping
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      addr_reg <= '0;
      op_reg <= '0;
      result_reg <= flash_status_pkg::RES_NONE;
      cnt_reg <= '0;
      reads_reg <= '0;
      busy_reg <= 1'b0;
      err_pending_reg <= 1'b0;
      sec_tog_reg <= 1'b0;
      first_reg <= '0;
      data_reg <= '0;
      sr_reg <= '0;
      cmd_reg <= '0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == flash_status_pkg::REG_ADDR && !busy_reg) begin
        addr_reg <= reg_wdata[flash_status_pkg::ADDR_W-1:0];
      end
      if (state_reg == st_idle && start) begin
        if (op_allowed) begin
          op_reg <= new_op;
          busy_reg <= 1'b1;
          reads_reg <= '0;
          cmd_reg <= cmd_word;
          cnt_reg <= is_write_op ? flash_status_pkg::CNT_W'(flash_status_pkg::WRITE_CYC)
            : flash_status_pkg::CNT_W'(flash_status_pkg::ACCESS_CYC);
          result_reg <= flash_status_pkg::RES_BUSY;
        end else begin
          result_reg <= flash_status_pkg::RES_REFUSED;
        end
      end else if (state_reg == st_wr) begin
        cnt_reg <= cnt_done ? flash_status_pkg::CNT_W'(flash_status_pkg::ACCESS_CYC) : cnt_reg - 1'b1;
        if (cnt_done && op_reg != flash_status_pkg::OP_SR_READ) begin
          busy_reg <= 1'b0;
          err_pending_reg <= 1'b0;
          result_reg <= flash_status_pkg::RES_DONE;
        end
      end else if (state_reg == st_rd) begin
        cnt_reg <= cnt_done ? flash_status_pkg::CNT_W'(flash_status_pkg::ACCESS_CYC) : cnt_reg - 1'b1;
        if (cnt_done) begin
          reads_reg <= reads_reg + 2'd1;
          if (reads_reg == 2'd0) begin
            first_reg <= dq_sync_reg;
          end
        end
      end else if (state_reg == st_eval) begin
        busy_reg <= 1'b0;
        data_reg <= dq_sync_reg;
        if (op_reg == flash_status_pkg::OP_POLL) begin
          result_reg <= poll_result;
          // toggling with timeout or abort leaves device error-locked
          err_pending_reg <= (poll_result == flash_status_pkg::RES_TIMEOUT)
            || (poll_result == flash_status_pkg::RES_ABORT);
          sec_tog_reg <= sec_toggling;
        end else if (op_reg == flash_status_pkg::OP_SR_READ) begin
          sr_reg <= dq_sync_reg[7:0];
          result_reg <= flash_status_pkg::RES_DONE;
        end else begin
          result_reg <= flash_status_pkg::RES_DONE;
        end
      end
    end
  end

  // flash pin drive
  assign flash_addr = (state_reg == st_wr) ? flash_status_pkg::CMD_ADDR : addr_reg;
  assign flash_ce_n = !(state_reg == st_wr || state_reg == st_rd);
  assign flash_oe_n = !(state_reg == st_rd);
  assign flash_we_n = !(state_reg == st_wr && !cnt_done);
  assign flash_dq_out = cmd_reg;
  assign flash_dq_oe_n = !(state_reg == st_wr);

  // register read port, data one cycle after strobe
  function automatic logic [3:0] sticky_hint(input logic [7:0] s);
    sticky_hint = {s[flash_status_pkg::SR_VALID], s[flash_status_pkg::SR_ERASE_ERR],
      s[flash_status_pkg::SR_PROG_ERR] | s[flash_status_pkg::SR_ABORT], s[flash_status_pkg::SR_PROTECT]};
  endfunction : sticky_hint
  wire [31:0] status_word = {21'd0, sec_tog_reg, rb_sync_reg, err_pending_reg, sticky_hint(sr_reg), result_reg,
    busy_reg};
  wire [31:0] rd_mux =
    (reg_addr == flash_status_pkg::REG_CTRL) ? {29'd0, op_reg} :
    (reg_addr == flash_status_pkg::REG_ADDR) ? {8'd0, addr_reg} :
    (reg_addr == flash_status_pkg::REG_STATUS) ? status_word :
    (reg_addr == flash_status_pkg::REG_POLL) ? {16'd0, first_reg[15:8], poll_mask(data_reg)} :
    (reg_addr == flash_status_pkg::REG_SR) ? {24'd0, sr_reg} :
    (reg_addr == flash_status_pkg::REG_DATA) ? {16'd0, data_reg} : 32'd0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 32'd0;
    end
  end
endmodule : flash_status_host

// ===== hw/flash_status_pkg.sv
// constants for the flash status and error handling controller
package flash_status_pkg;
  // flash data bus and polling bit positions
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_ONE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int ERASE_STARTED_BIT = 3;
  localparam int SECTOR_TOGGLE_BIT = 2;
  localparam int ABORT_BIT = 1;
  // operation status register bit positions
  localparam int SR_VALID = 7;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_ABORT = 3;
  localparam int SR_SUSPEND = 2;
  localparam int SR_PROTECT = 1;
  // device command words, single cycle, unlock cycles not issued
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [15:0] CMD_SR_READ = 16'h0070;
  localparam logic [15:0] CMD_SR_CLEAR = 16'h0071;
  localparam logic [15:0] CMD_ABORT_RESET = 16'h00f0;
  localparam logic [ADDR_W-1:0] CMD_ADDR = 24'h000555;
  // bus timing at 25 MHz: 40 ns per cycle
  localparam int CLK_NS = 40;
  localparam int ACCESS_NS = 100;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_NS = 60;
  localparam int WRITE_CYC = (WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  // own register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_POLL = 4'h3;
  localparam logic [3:0] REG_SR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h5;
  // control opcodes written to REG_CTRL
  localparam logic [2:0] OP_POLL = 3'h1;
  localparam logic [2:0] OP_SR_READ = 3'h2;
  localparam logic [2:0] OP_CLEAR = 3'h3;
  localparam logic [2:0] OP_ABORT_RESET = 3'h4;
  localparam logic [2:0] OP_ARRAY_READ = 3'h5;
  // result codes
  localparam logic [2:0] RES_NONE = 3'h0;
  localparam logic [2:0] RES_BUSY = 3'h1;
  localparam logic [2:0] RES_DONE = 3'h2;
  localparam logic [2:0] RES_TIMEOUT = 3'h3;
  localparam logic [2:0] RES_ABORT = 3'h4;
  localparam logic [2:0] RES_REFUSED = 3'h5;
endpackage : flash_status_pkg

// ===== test/flash_status_host_assertions.sv
// port checker for the flash status host
`timescale 1ns/10ps
module flash_status_host_assertions (
  // watched ports
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [flash_status_pkg::ADDR_W-1:0] flash_addr,
  input wire logic flash_dq_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  cmd_addr_a:
    assert property (!flash_we_n |-> flash_addr == flash_status_pkg::CMD_ADDR) else $error("command off address");
  cmd_drive_a:
    assert property (!flash_we_n |-> !flash_dq_oe_n && !flash_ce_n && flash_oe_n) else $error("command not driven");
  read_release_a:
    assert property (!flash_oe_n |-> flash_dq_oe_n && !flash_ce_n) else $error("bus fight on read");
  read_addr_a:
    assert property (!flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr)) else $error("address moved in read");
  read_len_a:
    assert property ($fell(flash_oe_n) |-> (!flash_oe_n)[*4] ##1 flash_oe_n) else $error("read cycle length");
  write_len_a:
    assert property ($fell(flash_we_n) |-> ##1 !flash_we_n ##1 flash_we_n) else $error("write strobe length");
  rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
  poll_mask_a:
    assert property ($past(reg_rd) && $past(reg_addr) == flash_status_pkg::REG_POLL |-> reg_rdata[4] == 1'b0
      && reg_rdata[0] == 1'b0) else $error("reserved bits unmasked");
endmodule : flash_status_host_assertions
bind flash_status_host flash_status_host_assertions chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_oe_n(flash_dq_oe_n),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// ===== test/flash_dev_model.sv
// behavioural flash device: status overlay, status register, clearing
`timescale 1ns/10ps
module flash_dev_model (
  // host pins
  input wire logic [flash_status_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  output logic [15:0] flash_dq_in,
  output logic ready_busy_n,
  // bench control
  input wire logic go,
  input wire logic [2:0] go_mode,
  input wire logic [15:0] last_word
);
  logic [2:0] mode = 3'h0;
  logic tog = 1'b0;
  logic sr_arm = 1'b0;
  logic sr_seen = 1'b0;
  logic prot = 1'b0;
  logic [15:0] held = 16'h0;
  wire sr_next = sr_arm != sr_seen;
  wire ers = mode >= 3'h4;
  wire sec = mode == 3'h4 || mode == 3'h5 || (mode == 3'h6 && flash_addr[23:16] == 8'h01);
  wire [7:0] st = {ers ? 1'b0 : ~last_word[7], tog, mode == 3'h2 || mode == 3'h4, tog, ers, sec & tog,
    mode == 3'h3, ~tog};
  wire [7:0] sr = mode == 3'h0 ? {2'h2, prot, 3'h0, prot, 1'b0} : mode == 3'h2 ? 8'h90 : mode == 3'h3 ? 8'h98 :
    mode == 3'h4 ? 8'ha0 : 8'h00;
  wire [15:0] word = sr_next ? {8'h00, sr} : mode == 3'h0 ? last_word : {last_word[15:8], st};
  assign ready_busy_n = mode == 3'h0;
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? word : ~held;
  always @(posedge flash_oe_n) begin
    held = word;
    tog = (mode != 3'h0) ? ~tog : tog;
    sr_seen = sr_arm;
  end
  always @(posedge flash_we_n or posedge go) begin
    if (go) begin
      prot <= mode == 3'h5;
      mode <= go_mode;
    end else if (flash_dq_out == flash_status_pkg::CMD_SR_READ) begin
      sr_arm <= ~sr_seen;
    end else if (mode inside {3'h2, 3'h3, 3'h4} && (flash_dq_out == flash_status_pkg::CMD_RESET ||
      flash_dq_out == flash_status_pkg::CMD_SR_CLEAR)) begin
      mode <= 3'h0;
    end
  end
endmodule : flash_dev_model

// ===== test/flash_status_host_test.sv
// self-checking bench for the flash status host
`timescale 1ns/10ps
module flash_status_host_test;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic [2:0] go_mode = 3'h0;
  logic [15:0] word = 16'h0;
  logic [31:0] reg_rdata;
  logic [23:0] flash_addr;
  logic [15:0] dq_in, dq_out;
  logic dq_oe_n, ce_n, oe_n, we_n, rb_n;
  int err_total = 0;
  int check_count = 0;
  always #20 sys_clk = ~sys_clk;
  flash_status_host uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
    .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .ready_busy_n(rb_n));
  flash_dev_model dev (.flash_addr(flash_addr), .flash_dq_out(dq_out), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_dq_in(dq_in), .ready_busy_n(rb_n), .go(go), .go_mode(go_mode), .last_word(word));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic op(input logic [2:0] c);
    logic [31:0] s;
    wr(flash_status_pkg::REG_CTRL, 32'(c));
    s = 32'h1;
    for (int k = 0; k < 60 && s[0] !== 1'b0; k++) rd(flash_status_pkg::REG_STATUS, s);
    chk(32'(s[0]), 32'h0);
  endtask : op
  task automatic set_mode(input logic [2:0] m);
    @(posedge sys_clk);
    go_mode <= m;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
  endtask : set_mode
  function automatic logic [7:0] exp_poll(input int m, input logic [15:0] w);
    if (m == 0) return w[7:0] & 8'hee;
    return {m inside {1, 2, 3} ? ~w[7] : 1'b0, 1'b0, 1'(m == 2 || m == 4), 1'b0, 1'(m >= 4), 1'b0, 1'(m == 3), 1'b0};
  endfunction : exp_poll
  function automatic logic [2:0] exp_res(input int m);
    if (m == 0) return flash_status_pkg::RES_DONE;
    if (m == 3) return flash_status_pkg::RES_ABORT;
    return (m == 2 || m == 4) ? flash_status_pkg::RES_TIMEOUT : flash_status_pkg::RES_BUSY;
  endfunction : exp_res
  function automatic logic [7:0] exp_sr(input int m);
    return m == 0 ? 8'h80 : m == 2 ? 8'h90 : m == 3 ? 8'h98 : m == 4 ? 8'ha0 : 8'h00;
  endfunction : exp_sr
  function automatic logic [3:0] exp_hint(input logic [7:0] s);
    return {s[7], s[5], s[4] | s[3], s[1]};
  endfunction : exp_hint
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #400000;
    err_total++;
    final_report;
  end
  initial begin
    logic [31:0] v;
    logic [31:0] a;
    int m;
    word = 16'($urandom(3));
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(4'hf, v);
    chk(v, 32'h0);
    for (int i = 0; i < 8; i++) begin
      m = (i == 7) ? 6 : i;
      word <= 16'($urandom());
      set_mode(3'(m));
      a = {8'h00, (i == 7) ? 8'h02 : 8'h01, 16'($urandom())};
      wr(flash_status_pkg::REG_ADDR, a);
      op(flash_status_pkg::OP_POLL);
      rd(flash_status_pkg::REG_STATUS, v);
      chk(32'(v[3:1]), 32'(exp_res(m)));
      chk(32'(v[8]), 32'(m inside {2, 3, 4}));
      chk(32'(v[10]), 32'(m == 4 || m == 5 || (m == 6 && i == 6)));
      rd(flash_status_pkg::REG_POLL, v);
      chk(32'(v[7:0] & (m == 0 ? 8'hff : 8'haa)), 32'(exp_poll(m, word)));
      if (m inside {2, 3, 4}) begin
        op(flash_status_pkg::OP_ARRAY_READ);
        rd(flash_status_pkg::REG_STATUS, v);
        chk(32'(v[3:1]), 32'(flash_status_pkg::RES_REFUSED));
      end
      op(flash_status_pkg::OP_SR_READ);
      rd(flash_status_pkg::REG_SR, v);
      chk(32'(v[7:0]), 32'(exp_sr(m)));
      rd(flash_status_pkg::REG_STATUS, v);
      chk(32'(v[7:4]), 32'(exp_hint(exp_sr(m))));
      if (m >= 2 && m <= 5) begin
        op(m == 3 ? flash_status_pkg::OP_ABORT_RESET : flash_status_pkg::OP_CLEAR);
        repeat (4) @(posedge sys_clk);
        rd(flash_status_pkg::REG_STATUS, v);
        chk(32'(v[9]), 32'(m != 5));
        op(flash_status_pkg::OP_SR_READ);
        rd(flash_status_pkg::REG_SR, v);
        chk(32'(v[7:0]), 32'(m == 5 ? 8'h00 : 8'h80));
      end
      set_mode(3'h0);
      if (m == 5) begin
        op(flash_status_pkg::OP_SR_READ);
        rd(flash_status_pkg::REG_SR, v);
        chk(32'(v[7:0]), 32'ha2);
        op(flash_status_pkg::OP_ARRAY_READ);
        rd(flash_status_pkg::REG_DATA, v);
        chk(v, {16'h0, word});
      end
    end
    clk_en <= 1'b0;
    wr(flash_status_pkg::REG_ADDR, 32'h00000abc);
    clk_en <= 1'b1;
    rd(flash_status_pkg::REG_ADDR, v);
    chk(v, a);
    final_report;
  end
endmodule : flash_status_host_test
